// ===== hw/lics_consts.svh
// Register offsets, field positions, reset values and timing counts of the charge sequencer
`ifndef LICS_CONSTS_SVH
`define LICS_CONSTS_SVH
`define LICS_ADDR_CHG_CTRL  8'h01
`define LICS_ADDR_SUPV      8'h02
`define LICS_ADDR_TMR_STAT  8'h04
`define LICS_CTRL_RESET     8'h43
`define LICS_SUPV_RESET     3'h6
`define LICS_TMR_CLR_BIT    0
`define LICS_ICC_MAX_CODE   4'h9
`define LICS_ICC_STEP_MA    100
`define LICS_PREQ_PCT       10
`define LICS_EOC_LO_PCT     5
`define LICS_EOC_HI_PCT     10
`define LICS_PREQ_USB_MA    11'h032
`define LICS_VTERM_41_MV    13'h1004
`define LICS_VTERM_42_MV    13'h1068
`define LICS_VTERM_438_MV   13'h111c
`define LICS_VRST_39_MV     13'h0f3c
`define LICS_VRST_40_MV     13'h0fa0
`define LICS_VRST_42_MV     13'h1068
`define LICS_CLK_MHZ        100
`define LICS_TICK_MS        1
`define LICS_TICK_CYC       (`LICS_CLK_MHZ * 1000 * `LICS_TICK_MS)
`define LICS_TOPOFF_MIN     21
`define LICS_TOPOFF_TICKS   (`LICS_TOPOFF_MIN * 60 * 1000 / `LICS_TICK_MS)
`define LICS_PREQ_HOUR      1
`define LICS_PREQ_TICKS     (`LICS_PREQ_HOUR * 3600 * 1000 / `LICS_TICK_MS)
`define LICS_SAFE_HOUR      10
`define LICS_SAFE_TICKS     (`LICS_SAFE_HOUR * 3600 * 1000 / `LICS_TICK_MS)
`define LICS_PRESC_W        17
`define LICS_TICK_W         26
`endif

// ===== hw/lics_pkg.sv
// Types of the charge sequencer
package lics_pkg;
`include "lics_consts.svh"

    typedef enum logic [7:0] {
        S_OFF     = 8'h01,
        S_PREQ    = 8'h02,
        S_CC      = 8'h04,
        S_CV      = 8'h08,
        S_FAULT   = 8'h10,
        S_DONE    = 8'h20,
        S_EXPIRED = 8'h40,
        S_TOPOFF  = 8'h80
    } lics_phase_t;

    typedef struct packed {
        logic       adapterPowerInput;
        logic       usbPowerInput;
        logic       usbSuspend;
        logic       battAboveFullRateThreshold;
        logic       battAtTermVoltage;
        logic       battBelowRestart;
        logic       currentAtEoc;
        logic       tempInWindow;
        logic       thermalShutdown;
    } lics_pins_t;

    typedef struct packed {
        logic [1:0] termSel;
        logic [3:0] iccCode;
        logic       chargeEnable;
        logic       eocSel;
    } lics_ctrl_t;

    typedef struct packed {
        logic       ledCurrentHigh;
        logic       ledEnable;
        logic       tempWindow45;
    } lics_supv_t;

    typedef struct packed {
        lics_phase_t                 phase;
        logic [2:0]                  code;
        lics_ctrl_t                  ctrl;
        lics_supv_t                  supv;
        logic                        tmrFlag;
        logic [`LICS_PRESC_W-1:0]    presc;
        logic [`LICS_TICK_W-1:0]     safeCnt;
        logic [`LICS_TICK_W-1:0]     topCnt;
        logic [7:0]                  rdData;
        lics_pins_t                  sync1;
        lics_pins_t                  sync2;
        logic                        prevPower;
        logic                        prevSrc;
        logic                        prevEn;
        logic                        prevTsd;
        logic                        prevTempOk;
        logic                        prevSusp;
        logic [10:0]                 chgMa;
        logic [10:0]                 eocMa;
        logic [12:0]                 termMv;
        logic [12:0]                 rstMv;
    } lics_state_t;
endpackage

// ===== hw/lics_charge_sequencer.sv
// Charge phase sequencer with safety timer and charger registers
//
// Functional notes
// - Below the full-rate threshold charge at 10 % of full rate from the adapter or 50 mA from USB, code 001.
// - On reaching the full-rate threshold charge at the full-rate current, code 010.
// - On reaching termination voltage hold that voltage while current tapers, code 011.
// - Bit 0 sets end-of-charge at 5 % or 10 % of full rate, reset 1, and reaching it starts top-off.
// - Top-off keeps constant voltage for 21 minutes with code 111, then the cycle is complete.
// - Cycle complete stops charging regardless of enable, code 101; below restart it resumes full rate when enabled, else goes to code 000.
// - Restart voltage is 3.9 V, 4.0 V or 4.2 V for the three termination settings.
// - Charge only inside the 0-50 C window, or 0-45 C when selected, else suspend with code 100.
// - Clearing charge enable stops charging with code 000, setting it resumes, reset value 1.
// - Safety timer limits pre-qualification to 1 h and the whole charge to 10 h including it.
// - Safety timer expiry during charging raises an interrupt and a pollable status bit.
// - Timer restarts on power arriving, source swap, recharge with enable, and enable toggled back on.
// - Timer restarts leaving thermal shutdown, on temperature recovery with enable, and on USB suspend end while USB is the only source.
`timescale 1ns/1ps
module lics_charge_sequencer
    import lics_pkg::*;
#(
    parameter logic [`LICS_PRESC_W-1:0] TICK_CYCLES   = `LICS_PRESC_W'(`LICS_TICK_CYC),
    parameter logic [`LICS_TICK_W-1:0]  TOPOFF_TICKS  = `LICS_TICK_W'(`LICS_TOPOFF_TICKS),
    parameter logic [`LICS_TICK_W-1:0]  PREQ_TICKS    = `LICS_TICK_W'(`LICS_PREQ_TICKS),
    parameter logic [`LICS_TICK_W-1:0]  SAFE_TICKS    = `LICS_TICK_W'(`LICS_SAFE_TICKS)
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output logic      [7:0]  regRdData,
    // Sense inputs from pins and comparators
    input  wire lics_pins_t  pins,
    // Charger drive
    output logic             chargePassTransistorOn,
    output logic             cvMode,
    output logic             usbPathOn,
    output logic      [10:0] chargeCurrentMa,
    output logic      [10:0] eocCurrentMa,
    output logic      [12:0] termVoltMv,
    output logic      [12:0] restartVoltMv,
    output logic             tempWindow45,
    // Status
    output logic      [2:0]  stateCode,
    output logic             ledEnable,
    output logic             ledCurrentHigh,
    output logic             timerIrq
);

    localparam lics_state_t ST_RESET = '{
        phase:      S_OFF,
        ctrl:       `LICS_CTRL_RESET,
        supv:       `LICS_SUPV_RESET,
        prevEn:     1'b1,
        prevTempOk: 1'b1,
        default:    '0
    };

    lics_state_t st_r;
    lics_state_t st_nxt;
    lics_pins_t  p;
    logic        powerOk;
    logic        restart;
    logic        tick;
    logic        charging;
    logic        expire;
    logic [10:0] iccSteps;
    logic [10:0] fullMa;
    logic [10:0] preqMa;

    function automatic logic [2:0] codeOf(input lics_phase_t ph);
        case (ph)
            S_OFF:     codeOf = 3'h0;
            S_PREQ:    codeOf = 3'h1;
            S_CC:      codeOf = 3'h2;
            S_CV:      codeOf = 3'h3;
            S_FAULT:   codeOf = 3'h4;
            S_DONE:    codeOf = 3'h5;
            S_EXPIRED: codeOf = 3'h6;
            S_TOPOFF:  codeOf = 3'h7;
            default:   codeOf = 3'h0;
        endcase
    endfunction

    always_comb begin
        st_nxt = st_r;
        // First stage feeds only the second stage
        st_nxt.sync1 = pins;
        st_nxt.sync2 = st_r.sync1;
        p = st_r.sync2;

        // Suspended USB counts as no power at all
        powerOk = p.adapterPowerInput | (p.usbPowerInput & ~p.usbSuspend);

        restart = (powerOk & ~st_r.prevPower)
                | (powerOk & st_r.prevPower & (p.adapterPowerInput != st_r.prevSrc))
                | (st_r.ctrl.chargeEnable & ~st_r.prevEn)
                | ((st_r.phase == S_DONE) & p.battBelowRestart & st_r.ctrl.chargeEnable)
                | (~p.thermalShutdown & st_r.prevTsd)
                | (p.tempInWindow & ~st_r.prevTempOk & st_r.ctrl.chargeEnable)
                | (~p.usbSuspend & st_r.prevSusp & p.usbPowerInput & ~p.adapterPowerInput);

        st_nxt.prevPower  = powerOk;
        st_nxt.prevSrc    = p.adapterPowerInput;
        st_nxt.prevEn     = st_r.ctrl.chargeEnable;
        st_nxt.prevTsd    = p.thermalShutdown;
        st_nxt.prevTempOk = p.tempInWindow;
        st_nxt.prevSusp   = p.usbSuspend;

        // Millisecond tick keeps the hour counters narrow
        tick = (st_r.presc == TICK_CYCLES - 1'b1);
        st_nxt.presc = tick ? '0 : st_r.presc + 1'b1;

        charging = (st_r.phase == S_PREQ) | (st_r.phase == S_CC) | (st_r.phase == S_CV);
        if (restart) begin
            st_nxt.safeCnt = '0;
        end else if (charging && tick && st_r.safeCnt != '1) begin
            st_nxt.safeCnt = st_r.safeCnt + 1'b1;
        end

        if (st_r.phase != S_TOPOFF) begin
            st_nxt.topCnt = '0;
        end else if (tick) begin
            st_nxt.topCnt = st_r.topCnt + 1'b1;
        end

        // Prequal time stays in the count, so the 10 h cap already subtracts it
        expire = ((st_r.phase == S_PREQ) && (st_r.safeCnt >= PREQ_TICKS))
               | (((st_r.phase == S_CC) || (st_r.phase == S_CV)) && (st_r.safeCnt >= SAFE_TICKS));

        if (!powerOk) begin
            st_nxt.phase = S_OFF;
        end else if (st_r.phase == S_EXPIRED && !restart) begin
            st_nxt.phase = S_EXPIRED;
        end else if (st_r.phase == S_DONE) begin
            if (p.battBelowRestart) begin
                st_nxt.phase = st_r.ctrl.chargeEnable ? S_CC : S_OFF;
            end else begin
                st_nxt.phase = S_DONE;
            end
        end else if (!st_r.ctrl.chargeEnable) begin
            st_nxt.phase = S_OFF;
        end else if (!p.tempInWindow || p.thermalShutdown) begin
            st_nxt.phase = S_FAULT;
        end else if (expire) begin
            st_nxt.phase = S_EXPIRED;
        end else begin
            case (st_r.phase)
                S_PREQ: begin
                    if (p.battAboveFullRateThreshold) begin
                        st_nxt.phase = S_CC;
                    end
                end
                S_CC: begin
                    if (p.battAtTermVoltage) begin
                        st_nxt.phase = S_CV;
                    end
                end
                S_CV: begin
                    if (p.currentAtEoc) begin
                        st_nxt.phase = S_TOPOFF;
                    end
                end
                S_TOPOFF: begin
                    if (st_r.topCnt >= TOPOFF_TICKS) begin
                        st_nxt.phase = S_DONE;
                    end
                end
                default: begin
                    st_nxt.phase = p.battAboveFullRateThreshold ? S_CC : S_PREQ;
                end
            endcase
        end
        st_nxt.code = codeOf(st_nxt.phase);

        // Registers; a new expiry beats a clear in the same cycle
        if (regWrEn && regAddr == `LICS_ADDR_CHG_CTRL) begin
            st_nxt.ctrl = lics_ctrl_t'(regWrData);
        end
        if (regWrEn && regAddr == `LICS_ADDR_SUPV) begin
            st_nxt.supv = lics_supv_t'(regWrData[5:3]);
        end
        if (regWrEn && regAddr == `LICS_ADDR_TMR_STAT && regWrData[`LICS_TMR_CLR_BIT]) begin
            st_nxt.tmrFlag = 1'b0;
        end
        if (expire && st_nxt.phase == S_EXPIRED) begin
            st_nxt.tmrFlag = 1'b1;
        end

        case (regAddr)
            `LICS_ADDR_CHG_CTRL: st_nxt.rdData = st_r.ctrl;
            `LICS_ADDR_SUPV:     st_nxt.rdData = {2'h0, st_r.supv, st_r.code};
            `LICS_ADDR_TMR_STAT: st_nxt.rdData = {7'h00, st_r.tmrFlag};
            default:             st_nxt.rdData = 8'h00;
        endcase

        // Codes above 1001 clamp to 1000 mA
        iccSteps = (st_r.ctrl.iccCode > `LICS_ICC_MAX_CODE) ? 11'h00a : 11'({7'h00, st_r.ctrl.iccCode}) + 11'h001;
        fullMa = 11'(32'(iccSteps) * `LICS_ICC_STEP_MA);
        preqMa = p.adapterPowerInput ? 11'(32'(fullMa) * `LICS_PREQ_PCT / 100)
                                     : `LICS_PREQ_USB_MA;
        st_nxt.eocMa = st_r.ctrl.eocSel ? 11'(32'(fullMa) * `LICS_EOC_HI_PCT / 100)
                                        : 11'(32'(fullMa) * `LICS_EOC_LO_PCT / 100);
        case (st_r.phase)
            S_PREQ:               st_nxt.chgMa = preqMa;
            S_CC, S_CV, S_TOPOFF: st_nxt.chgMa = fullMa;
            default:              st_nxt.chgMa = 11'h000;
        endcase

        // Reserved termination code falls back to the reset setting
        case (st_r.ctrl.termSel)
            2'h0: begin
                st_nxt.termMv = `LICS_VTERM_41_MV;
                st_nxt.rstMv  = `LICS_VRST_39_MV;
            end
            2'h2: begin
                st_nxt.termMv = `LICS_VTERM_438_MV;
                st_nxt.rstMv  = `LICS_VRST_42_MV;
            end
            default: begin
                st_nxt.termMv = `LICS_VTERM_42_MV;
                st_nxt.rstMv  = `LICS_VRST_40_MV;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData              = st_r.rdData;
    assign chargePassTransistorOn = charging | (st_r.phase == S_TOPOFF);
    assign cvMode                 = (st_r.phase == S_CV) | (st_r.phase == S_TOPOFF);
    assign usbPathOn              = chargePassTransistorOn & ~p.adapterPowerInput;
    assign chargeCurrentMa        = st_r.chgMa;
    assign eocCurrentMa           = st_r.eocMa;
    assign termVoltMv             = st_r.termMv;
    assign restartVoltMv          = st_r.rstMv;
    assign tempWindow45           = st_r.supv.tempWindow45;
    assign stateCode              = st_r.code;
    assign ledEnable              = st_r.supv.ledEnable;
    assign ledCurrentHigh         = st_r.supv.ledCurrentHigh;
    assign timerIrq               = st_r.tmrFlag;

endmodule // lics_charge_sequencer

// ===== sim/lics_checker.sv
// Port assertions of the charge sequencer
`timescale 1ns/1ps
module lics_checker
    import lics_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Register port
    input wire logic        regWrEn,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    // Drive and status
    input wire logic        chargePassTransistorOn,
    input wire logic        cvMode,
    input wire logic        usbPathOn,
    input wire logic [10:0] chargeCurrentMa,
    input wire logic [10:0] eocCurrentMa,
    input wire logic [12:0] termVoltMv,
    input wire logic [12:0] restartVoltMv,
    input wire logic [2:0]  stateCode,
    input wire logic        timerIrq
);
    logic [7:0] ctl_r;
    logic [1:0] up_r;
    logic [4:0] top_r;
    // Codes above 1001 clamp to the top step
    function automatic logic [10:0] fullOf(logic [7:0] c);
        return (c[5:2] > 4'h9) ? 11'h3e8 : 11'(c[5:2]) * 11'h064 + 11'h064;
    endfunction
    function automatic logic [25:0] voltOf(logic [1:0] t);
        case (t)
            2'h0: return {13'h1004, 13'h0f3c};
            2'h2: return {13'h111c, 13'h1068};
            default: return {13'h1068, 13'h0fa0};
        endcase
    endfunction
    // Decoded outputs are zero until the first edge after reset, so they are judged only once settled
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctl_r <= 8'h43;
            up_r <= 2'h0;
            top_r <= 5'h00;
        end else begin
            if (regWrEn && regAddr == 8'h01) begin
                ctl_r <= regWrData;
            end
            up_r <= (up_r == 2'h2) ? up_r : up_r + 2'h1;
            top_r <= (stateCode == 3'h7) ? top_r + 5'h01 : 5'h00;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_pass_code: assert property (
        chargePassTransistorOn == (stateCode inside {3'h1, 3'h2, 3'h3, 3'h7}))
        else $error("pass device disagrees with state code");
    a_cv_code: assert property (
        cvMode == (stateCode inside {3'h3, 3'h7}))
        else $error("voltage mode disagrees with state code");
    a_term_volt: assert property (
        up_r == 2'h2 |-> {termVoltMv, restartVoltMv} == voltOf($past(ctl_r[7:6])))
        else $error("termination or restart voltage wrong");
    a_eoc_level: assert property (
        up_r == 2'h2 |-> eocCurrentMa == ($past(ctl_r[0]) ? fullOf($past(ctl_r)) / 11'h00a
                                                           : fullOf($past(ctl_r)) / 11'h014))
        else $error("end of charge level wrong");
    a_cc_current: assert property (
        stateCode == 3'h2 && $past(stateCode) == 3'h2 |-> chargeCurrentMa == fullOf($past(ctl_r)))
        else $error("full rate current wrong");
    a_preq_current: assert property (
        stateCode == 3'h1 && $past(stateCode) == 3'h1 |->
        chargeCurrentMa == ($past(usbPathOn) ? 11'h032 : fullOf($past(ctl_r)) / 11'h00a))
        else $error("prequal current wrong");
    a_topoff_len: assert property (
        stateCode == 3'h5 && $past(stateCode) == 3'h7 |-> top_r inside {[5'h0f:5'h1a]})
        else $error("top off period wrong");
    a_irq_expired: assert property (
        $rose(stateCode == 3'h6) |-> ##[0:1] timerIrq)
        else $error("no interrupt on timer expiry");
endmodule // lics_checker
bind lics_charge_sequencer lics_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .chargePassTransistorOn(chargePassTransistorOn), .cvMode(cvMode),
    .usbPathOn(usbPathOn), .chargeCurrentMa(chargeCurrentMa), .eocCurrentMa(eocCurrentMa),
    .termVoltMv(termVoltMv), .restartVoltMv(restartVoltMv), .stateCode(stateCode), .timerIrq(timerIrq));

// ===== sim/lics_batt_model.sv
// Cell and power source model facing the charge sequencer
`timescale 1ns/1ps
module lics_batt_model
    import lics_pkg::*;
#(
    parameter logic [12:0] FULL_RATE_MV = 13'h0b22,
    parameter logic [12:0] STEP_MV      = 13'h0020
) (
    // Clock
    input wire logic        sys_clk,
    // Charger drive
    input wire logic        chargePassTransistorOn,
    input wire logic        cvMode,
    input wire logic [10:0] chargeCurrentMa,
    input wire logic [10:0] eocCurrentMa,
    input wire logic [12:0] termVoltMv,
    input wire logic [12:0] restartVoltMv,
    // Scenario control: adapter, usb, suspend, thermal shutdown
    input wire logic [3:0]  env,
    input wire logic        tempOk,
    input wire logic        stall,
    input wire logic        load,
    input wire logic [12:0] loadMv,
    // Sense lines
    output lics_pins_t      pins
);
    logic [12:0] vBat_r;
    logic [10:0] iBat_r;
    // Cell rises only under current and never past the regulated voltage; stall models a dead cell
    always @(posedge sys_clk) begin
        if (load) begin
            vBat_r <= loadMv;
        end else if (chargePassTransistorOn && !cvMode && !stall) begin
            vBat_r <= (vBat_r + STEP_MV > termVoltMv) ? termVoltMv : vBat_r + STEP_MV;
        end
        iBat_r <= cvMode ? ((iBat_r > 11'h00a) ? iBat_r - 11'h00a : 11'h000) : chargeCurrentMa;
    end
    assign pins = lics_pins_t'({env[3:1], vBat_r >= FULL_RATE_MV, vBat_r >= termVoltMv,
                                vBat_r < restartVoltMv, cvMode && iBat_r <= eocCurrentMa, tempOk, env[0]});
endmodule // lics_batt_model

// ===== sim/testbench.sv
// Self-checking bench of the charge sequencer
`timescale 1ns/1ps
module testbench import lics_pkg::*;;
    logic        sys_clk, nrst, regWrEn, tempOk, stall, load;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic [3:0]  env;
    logic [12:0] loadMv, termVoltMv, restartVoltMv;
    logic [10:0] chargeCurrentMa, eocCurrentMa;
    logic [2:0]  stateCode;
    logic        passOn, cvMode, usbPathOn, tempWindow45, ledEnable, ledCurrentHigh, timerIrq;
    lics_pins_t  pins;
    int          n_errors = 0, tests_run = 0, cycles = 0;
    logic [12:0] tv [4] = '{13'h1004, 13'h1068, 13'h111c, 13'h1068};
    logic [12:0] rv [4] = '{13'h0f3c, 13'h0fa0, 13'h1068, 13'h0fa0};
    // Shortened counts keep the run to a few hundred cycles
    lics_charge_sequencer #(.TICK_CYCLES(17'h00004), .TOPOFF_TICKS(26'h0000005), .PREQ_TICKS(26'h000000a),
        .SAFE_TICKS(26'h000001e)) DUT (.sys_clk(sys_clk), .nrst(nrst), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .pins(pins), .chargePassTransistorOn(passOn),
        .cvMode(cvMode), .usbPathOn(usbPathOn), .chargeCurrentMa(chargeCurrentMa), .eocCurrentMa(eocCurrentMa),
        .termVoltMv(termVoltMv), .restartVoltMv(restartVoltMv), .tempWindow45(tempWindow45),
        .stateCode(stateCode), .ledEnable(ledEnable), .ledCurrentHigh(ledCurrentHigh), .timerIrq(timerIrq));
    lics_batt_model BATT (.sys_clk(sys_clk), .chargePassTransistorOn(passOn), .cvMode(cvMode),
        .chargeCurrentMa(chargeCurrentMa), .eocCurrentMa(eocCurrentMa), .termVoltMv(termVoltMv),
        .restartVoltMv(restartVoltMv), .env(env), .tempOk(tempOk), .stall(stall), .load(load), .loadMv(loadMv),
        .pins(pins));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        n_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail("watchdog expired");
            close_out();
        end
    end
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail(what);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {regWrEn, regAddr, regWrData} = {1'b1, a, d};
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge sys_clk);
        regAddr = a;
        @(negedge sys_clk);
        check(13'(regRdData), 13'(exp), what);
    endtask
    task automatic setBatt(input logic [12:0] mv);
        @(negedge sys_clk);
        {load, loadMv} = {1'b1, mv};
        @(negedge sys_clk);
        load = 1'b0;
    endtask
    // Waits a bounded number of cycles for a state code, then judges it
    task automatic waitCode(input logic [2:0] c, input int lim, input string what);
        int k;
        k = 0;
        while (stateCode !== c && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        check(13'(stateCode), 13'(c), what);
    endtask
    task automatic t_regs();
        rd(8'h01, 8'h43, "control reset");
        rd(8'h02, 8'h30, "supervisor reset");
        check(13'({ledCurrentHigh, ledEnable}), 13'h0003, "led defaults");
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h38, "supervisor write mask");
        check(13'(tempWindow45), 13'h0001, "narrow window select");
        wr(8'h02, 8'h30);
        wr(8'h07, 8'h5a);
        rd(8'h07, 8'h00, "unmapped read");
        for (int k = 0; k < 10; k++) begin
            wr(8'h01, {k[1:0], k[3:0], 1'b1, k[0]});
            @(negedge sys_clk);
            check(termVoltMv, tv[k % 4], "termination voltage");
            check(restartVoltMv, rv[k % 4], "restart voltage");
            check(13'(eocCurrentMa), 13'((k + 1) * (k[0] ? 10 : 5)), "end of charge level");
        end
    endtask
    task automatic t_cycle();
        wr(8'h01, 8'h47);
        setBatt(13'h09c4);
        env = 4'h8;
        waitCode(3'h1, 10, "prequal");
        @(negedge sys_clk);
        check(13'(chargeCurrentMa), 13'h0014, "prequal current");
        waitCode(3'h2, 30, "full rate");
        @(negedge sys_clk);
        check(13'(chargeCurrentMa), 13'h00c8, "full rate current");
        waitCode(3'h3, 60, "constant voltage");
        waitCode(3'h7, 40, "top off");
        waitCode(3'h5, 40, "cycle complete");
        check(13'(passOn), 13'h0000, "charging stopped");
        setBatt(13'h0f3c);
        waitCode(3'h2, 10, "recharge");
    endtask
    task automatic t_enable_temp();
        setBatt(13'h0c80);
        wr(8'h01, 8'h45);
        waitCode(3'h0, 6, "disabled");
        wr(8'h01, 8'h47);
        waitCode(3'h2, 6, "enabled again");
        tempOk = 1'b0;
        waitCode(3'h4, 6, "temperature fault");
        check(13'(passOn), 13'h0000, "charging suspended");
        tempOk = 1'b1;
        waitCode(3'h2, 6, "temperature recovered");
    endtask
    task automatic t_timer();
        realtime t0;
        env = 4'h0;
        stall = 1'b1;
        setBatt(13'h09c4);
        env = 4'h8;
        waitCode(3'h1, 10, "power on");
        t0 = $realtime;
        waitCode(3'h6, 60, "prequal limit");
        check(13'(($realtime - t0) / 40.0), 13'h000a, "prequal limit length");
        check(13'(timerIrq), 13'h0001, "expiry interrupt");
        repeat (20) @(negedge sys_clk);
        check(13'(stateCode), 13'h0006, "expired hold");
        rd(8'h04, 8'h01, "timer status");
        wr(8'h04, 8'h01);
        rd(8'h04, 8'h00, "timer status cleared");
        wr(8'h01, 8'h45);
        wr(8'h01, 8'h47);
        waitCode(3'h1, 6, "enable toggle restart");
        t0 = $realtime;
        setBatt(13'h0bb8);
        waitCode(3'h6, 160, "full rate limit");
        check(13'(($realtime - t0) / 40.0), 13'h001e, "full rate limit length");
        env = 4'h4;
        waitCode(3'h2, 10, "source swap restart");
        check(13'(usbPathOn), 13'h0001, "usb path");
        env = 4'h6;
        waitCode(3'h0, 6, "usb suspended");
        env = 4'h4;
        waitCode(3'h2, 6, "suspend end restart");
        env = 4'h5;
        waitCode(3'h4, 6, "thermal shutdown");
        env = 4'h4;
        waitCode(3'h2, 6, "thermal shutdown end");
        // Counter frozen in the fault, so only a zeroed count gives the full span again
        t0 = $realtime;
        waitCode(3'h6, 160, "limit after shutdown");
        check(13'(($realtime - t0) / 40.0), 13'h001e, "restart after shutdown");
    endtask
    initial begin
        {nrst, regWrEn, regAddr, regWrData, env, tempOk, stall} = '0;
        tempOk = 1'b1;
        {load, loadMv} = {1'b1, 13'h0c80};
        repeat (5) @(negedge sys_clk);
        {nrst, load} = 2'b10;
        t_regs();
        t_cycle();
        t_enable_temp();
        t_timer();
        close_out();
    end
endmodule // testbench
